/* hw/msp_counter.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Up counter with synchronous clear, wraps at full scale
// ----------------------------------------------------------------------------
module msp_counter #(
   parameter int W = 24,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clr,
   input wire logic i_inc,
   output logic [W-1:0] o_value
);

   logic [W-1:0] cnt_q; // Count held in flops
   logic [W-1:0] cnt_d; // Next count

   // Clear wins; the two never meet in a legal sequence
   assign cnt_d = i_clr ? '0 : (i_inc ? cnt_q + {{(W-1){1'b0}}, 1'b1} : cnt_q);

   // Count register
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_q <= INIT;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   assign o_value = cnt_q;

endmodule : msp_counter
`default_nettype wire

/* hw/msp_hold.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// Loadable hold register with synchronous clear
// ----------------------------------------------------------------------------
module msp_hold #(
   parameter int W = 48
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clr,
   input wire logic i_load,
   input wire logic [W-1:0] i_data,
   output logic [W-1:0] o_value
);

   logic [W-1:0] hold_q; // Held value

   // Clear has priority over load
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         hold_q <= '0;
      end
      else if (i_clr)
      begin
         hold_q <= '0;
      end
      else if (i_load)
      begin
         hold_q <= i_data;
      end
   end

   assign o_value = hold_q;

endmodule : msp_hold
`default_nettype wire

/* hw/msp_mission_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module msp_mission_regs #(
   parameter logic [23:0] DEV_CNT_INIT = 24'h000000
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Byte register port from the serial protocol engine
   input wire logic [15:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_read_lock,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   output logic o_write_refused,
   // Commands, one-cycle pulses, already password-checked
   input wire logic i_clear_memory_cmd,
   input wire logic i_start_mission_cmd,
   input wire logic i_stop_mission_cmd,
   input wire logic i_forced_conv_cmd,
   // Configuration and timing events
   input wire logic i_alarm_triggered_start,
   input wire logic i_minute_tick,
   input wire logic i_sample_tick,
   input wire logic i_temp_alarm,
   input wire logic [msp_pkg::MSP_STAMP_W-1:0] i_rtc_time,
   // Status and action outputs
   output logic o_mission_active_flag,
   output logic o_memory_cleared_flag,
   output logic o_awaiting_alarm_flag,
   output logic o_take_sample,
   output logic o_alarm_test,
   output logic o_clear_alarm_flags,
   output logic o_start_refused
);
   import msp_pkg::*;

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   msp_state_e state_q; // Mission sequencer state
   msp_state_e state_d; // Next state
   logic active_q; // Mission in progress
   logic active_d;
   logic memory_cleared_flag_q; // Memory cleared since last mission
   logic memory_cleared_flag_d;
   logic awaiting_q; // Waiting for the starting alarm
   logic awaiting_d;
   logic [23:0] delay_q; // Programmed start delay
   logic [23:0] delay_d;
   logic [23:0] remain_q; // Minutes still to run before first action
   logic [23:0] remain_d;
   logic sample_q; // Registered wake-to-log pulse
   logic test_q; // Registered alarm-test pulse
   logic clr_alarm_q; // Registered alarm-flag clear pulse
   logic refused_q; // Registered start refusal pulse
   logic wr_refused_q; // Registered write refusal pulse
   logic [7:0] rdata_q; // Read data register
   logic rvalid_q; // Read data valid pulse
   logic lock_q; // Read lock seen last cycle

   logic start_ok; // Start accepted this cycle
   logic clear_ok; // Clear-memory accepted this cycle
   logic stop_ok; // Stop accepted this cycle
   logic first_log; // Entering logging by timed start
   logic alarm_start; // Starting alarm found while waiting
   logic log_tick; // Wake to measure and log
   logic test_tick; // Wake to test for the starting alarm
   logic stamp_load; // Capture first sample time
   logic msamp_inc; // Mission counter step
   logic dsamp_inc; // Device counter step
   logic delay_hit; // Delay write address
   logic [1:0] delay_sel; // Delay byte lane
   logic wr_ok; // Delay write accepted
   logic lock_rise; // Snapshot capture
   logic [MSP_STAMP_W-1:0] stamp_val; // Time stamp register set
   logic [23:0] msamp_val; // Mission samples counter
   logic [23:0] dsamp_val; // Device samples counter
   logic [119:0] live_view; // Live multi-byte values
   logic [119:0] snap_view; // Frozen copy for coherent reads
   logic [119:0] view; // What the host sees
   logic [7:0] status_byte; // Composed status byte
   logic [7:0] rd_byte; // Selected read byte

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   // Byte k of a little-endian 24-bit value
   function automatic logic [7:0] msp_byte3(input logic [23:0] v, input logic [1:0] k);
      logic [7:0] b;
      b = v[7:0];
      if (k == 2'h1)
      begin
         b = v[15:8];
      end
      else if (k == 2'h2)
      begin
         b = v[23:16];
      end
      return b;
   endfunction : msp_byte3

   // Offset of an address inside a three-byte group, or 3 when outside
   function automatic logic [1:0] msp_lane(input logic [15:0] a, input logic [15:0] base);
      logic [15:0] d;
      d = a - base;
      return (d < 16'h0003) ? d[1:0] : 2'h3;
   endfunction : msp_lane

   // ----------------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------------
   // Start needs an idle device with cleared memory
   assign start_ok = i_start_mission_cmd && (state_q == MSP_ST_IDLE) && memory_cleared_flag_q;
   // Clearing a running mission would corrupt its bookkeeping, so outside idle it is ignored
   assign clear_ok = i_clear_memory_cmd && (state_q == MSP_ST_IDLE) && !i_start_mission_cmd;
   assign stop_ok = i_stop_mission_cmd && (state_q != MSP_ST_IDLE);
   assign alarm_start = (state_q == MSP_ST_ALARM_WAIT) && i_temp_alarm;
   assign test_tick = (state_q == MSP_ST_ALARM_WAIT) && i_sample_tick && !i_temp_alarm && !stop_ok;
   assign log_tick = ((state_q == MSP_ST_LOGGING) && i_sample_tick && !stop_ok) || first_log;
   // First logged entry comes from the alarm conversion itself
   assign stamp_load = first_log || alarm_start;
   assign msamp_inc = log_tick;
   // Mission wakes, alarm tests and idle forced conversions
   assign dsamp_inc = log_tick || test_tick || ((state_q == MSP_ST_IDLE) && i_forced_conv_cmd);

   // ----------------------------------------------------------------------------
   // Mission sequencer
   // ----------------------------------------------------------------------------
   // Delay counts down on RTC minute ticks; zero delay acts at once
   always_comb
   begin
      state_d = state_q;
      remain_d = remain_q;
      first_log = 1'b0;
      unique case (state_q)
         MSP_ST_IDLE:
         begin
            if (start_ok)
            begin
               remain_d = delay_q;
               if (delay_q != MSP_DELAY_RESET)
               begin
                  state_d = MSP_ST_DELAY;
               end
               else if (i_alarm_triggered_start)
               begin
                  state_d = MSP_ST_ALARM_WAIT;
               end
               else
               begin
                  state_d = MSP_ST_LOGGING;
                  first_log = 1'b1;
               end
            end
         end
         MSP_ST_DELAY:
         begin
            if (stop_ok)
            begin
               state_d = MSP_ST_IDLE;
            end
            else if (i_minute_tick)
            begin
               remain_d = remain_q - MSP_CNT_ONE;
               // Full delay must expire first in both start modes
               if (remain_q == MSP_CNT_ONE)
               begin
                  if (awaiting_q)
                  begin
                     state_d = MSP_ST_ALARM_WAIT;
                  end
                  else
                  begin
                     state_d = MSP_ST_LOGGING;
                     first_log = 1'b1;
                  end
               end
            end
         end
         MSP_ST_ALARM_WAIT:
         begin
            if (stop_ok)
            begin
               state_d = MSP_ST_IDLE;
            end
            else if (alarm_start)
            begin
               state_d = MSP_ST_LOGGING;
            end
         end
         MSP_ST_LOGGING:
         begin
            if (stop_ok)
            begin
               state_d = MSP_ST_IDLE;
            end
         end
         default:
         begin
            state_d = MSP_ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------------------
   assign active_d = start_ok ? 1'b1 : (stop_ok ? 1'b0 : active_q);
   // Set by clear-memory, dropped by an accepted start
   assign memory_cleared_flag_d = clear_ok ? 1'b1 : (start_ok ? 1'b0 : memory_cleared_flag_q);
   // Survives stop and clear-memory; only an alarm clears it, start wins
   assign awaiting_d = (start_ok && i_alarm_triggered_start) ? 1'b1 :
                       (i_temp_alarm ? 1'b0 : awaiting_q);

   // Flag and sequencer registers
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= MSP_ST_IDLE;
         remain_q <= MSP_DELAY_RESET;
         active_q <= 1'b0;
         memory_cleared_flag_q <= 1'b0;
         awaiting_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         remain_q <= remain_d;
         active_q <= active_d;
         memory_cleared_flag_q <= memory_cleared_flag_d;
         awaiting_q <= awaiting_d;
      end
   end

   // Action pulses, registered for clean outputs
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sample_q <= 1'b0;
         test_q <= 1'b0;
         clr_alarm_q <= 1'b0;
         refused_q <= 1'b0;
      end
      else
      begin
         sample_q <= log_tick;
         test_q <= test_tick;
         clr_alarm_q <= clear_ok;
         refused_q <= i_start_mission_cmd && !start_ok;
      end
   end

   // ----------------------------------------------------------------------------
   // Start delay register
   // ----------------------------------------------------------------------------
   assign delay_sel = msp_lane(i_reg_addr, MSP_ADDR_DELAY_LOW);
   assign delay_hit = (delay_sel != 2'h3);
   // Writes only between missions
   assign wr_ok = i_reg_wr && delay_hit && (state_q == MSP_ST_IDLE) && !start_ok;
   assign delay_d = {(wr_ok && delay_sel == 2'h2) ? i_reg_wdata : delay_q[23:16],
                     (wr_ok && delay_sel == 2'h1) ? i_reg_wdata : delay_q[15:8],
                     (wr_ok && delay_sel == 2'h0) ? i_reg_wdata : delay_q[7:0]};

   // Delay bytes and write refusal
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         delay_q <= MSP_DELAY_RESET;
         wr_refused_q <= 1'b0;
      end
      else
      begin
         delay_q <= delay_d;
         // Any write that stores nothing, read-only targets included
         wr_refused_q <= i_reg_wr && !wr_ok;
      end
   end

   // ----------------------------------------------------------------------------
   // Time stamp and counters
   // ----------------------------------------------------------------------------
   // Six BCD bytes, seconds lowest; RTC bits such as 12/24 pass as is
   msp_hold #(.W(MSP_STAMP_W)) u_stamp (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clr(clear_ok),
      .i_load(stamp_load),
      .i_data(i_rtc_time),
      .o_value(stamp_val)
   );

   msp_counter #(.W(MSP_CNT_W), .INIT(MSP_CNT_ZERO)) u_msamp (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clr(clear_ok),
      .i_inc(msamp_inc),
      .o_value(msamp_val)
   );

   // Lifetime count, never cleared by commands
   msp_counter #(.W(MSP_CNT_W), .INIT(DEV_CNT_INIT)) u_dsamp (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clr(1'b0),
      .i_inc(dsamp_inc),
      .o_value(dsamp_val)
   );

   // ----------------------------------------------------------------------------
   // Coherent read snapshot
   // ----------------------------------------------------------------------------
   // Frozen at lock rise so a multi-byte read sees one instant
   assign live_view = {delay_q, dsamp_val, msamp_val, stamp_val};
   assign lock_rise = i_read_lock && !lock_q;
   assign view = lock_q ? snap_view : live_view;

   msp_hold #(.W(120)) u_snap (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clr(1'b0),
      .i_load(lock_rise),
      .i_data(live_view),
      .o_value(snap_view)
   );

   // ----------------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------------
   assign status_byte = {MSP_STATUS_TOP, MSP_STATUS_B5, awaiting_q, memory_cleared_flag_q,
                         MSP_STATUS_B2, active_q, MSP_STATUS_B0};

   // Address select; 021f and everything unmapped read zero
   always_comb
   begin
      rd_byte = MSP_UNMAPPED_DATA;
      if (i_reg_addr == MSP_ADDR_STATUS)
      begin
         rd_byte = status_byte;
      end
      else if (delay_hit)
      begin
         rd_byte = msp_byte3(view[119:96], delay_sel);
      end
      else if (msp_lane(i_reg_addr, MSP_ADDR_STAMP_SEC) != 2'h3)
      begin
         rd_byte = msp_byte3(view[23:0], msp_lane(i_reg_addr, MSP_ADDR_STAMP_SEC));
      end
      else if (msp_lane(i_reg_addr, MSP_ADDR_STAMP_DATE) != 2'h3)
      begin
         rd_byte = msp_byte3(view[47:24], msp_lane(i_reg_addr, MSP_ADDR_STAMP_DATE));
      end
      else if (msp_lane(i_reg_addr, MSP_ADDR_MSAMP_LOW) != 2'h3)
      begin
         rd_byte = msp_byte3(view[71:48], msp_lane(i_reg_addr, MSP_ADDR_MSAMP_LOW));
      end
      else if (msp_lane(i_reg_addr, MSP_ADDR_DSAMP_LOW) != 2'h3)
      begin
         rd_byte = msp_byte3(view[95:72], msp_lane(i_reg_addr, MSP_ADDR_DSAMP_LOW));
      end
   end

   // Read data register and lock edge detect
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rdata_q <= MSP_RDATA_RESET;
         rvalid_q <= 1'b0;
         lock_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= i_reg_rd;
         lock_q <= i_read_lock;
         if (i_reg_rd)
         begin
            rdata_q <= rd_byte;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------
   assign o_reg_rdata = rdata_q;
   assign o_reg_rvalid = rvalid_q;
   assign o_write_refused = wr_refused_q;
   assign o_mission_active_flag = active_q;
   assign o_memory_cleared_flag = memory_cleared_flag_q;
   assign o_awaiting_alarm_flag = awaiting_q;
   assign o_take_sample = sample_q;
   assign o_alarm_test = test_q;
   assign o_clear_alarm_flags = clr_alarm_q;
   assign o_start_refused = refused_q;

endmodule : msp_mission_regs
`default_nettype wire

/* hw/msp_pkg.sv */
// ----------------------------------------------------------------------------
// Register map and encodings for mission status and progress
// ----------------------------------------------------------------------------
package msp_pkg;

   // Register addresses
   localparam logic [15:0] MSP_ADDR_STATUS = 16'h0215;
   localparam logic [15:0] MSP_ADDR_DELAY_LOW = 16'h0216;
   localparam logic [15:0] MSP_ADDR_DELAY_MID = 16'h0217;
   localparam logic [15:0] MSP_ADDR_DELAY_HIGH = 16'h0218;
   localparam logic [15:0] MSP_ADDR_STAMP_SEC = 16'h0219;
   localparam logic [15:0] MSP_ADDR_STAMP_MIN = 16'h021a;
   localparam logic [15:0] MSP_ADDR_STAMP_HOUR = 16'h021b;
   localparam logic [15:0] MSP_ADDR_STAMP_DATE = 16'h021c;
   localparam logic [15:0] MSP_ADDR_STAMP_MONTH = 16'h021d;
   localparam logic [15:0] MSP_ADDR_STAMP_YEAR = 16'h021e;
   localparam logic [15:0] MSP_ADDR_MSAMP_LOW = 16'h0220;
   localparam logic [15:0] MSP_ADDR_MSAMP_MID = 16'h0221;
   localparam logic [15:0] MSP_ADDR_MSAMP_HIGH = 16'h0222;
   localparam logic [15:0] MSP_ADDR_DSAMP_LOW = 16'h0223;
   localparam logic [15:0] MSP_ADDR_DSAMP_MID = 16'h0224;
   localparam logic [15:0] MSP_ADDR_DSAMP_HIGH = 16'h0225;

   // Widths
   localparam int MSP_CNT_W = 24;
   localparam int MSP_STAMP_W = 48;

   // Fixed bits of the general status byte
   localparam logic [1:0] MSP_STATUS_TOP = 2'h3;
   localparam logic MSP_STATUS_B5 = 1'h0;
   localparam logic MSP_STATUS_B2 = 1'h0;
   localparam logic MSP_STATUS_B0 = 1'h0;

   // Reset values, unmapped read data and count constants
   localparam logic [7:0] MSP_RDATA_RESET = 8'h00;
   localparam logic [7:0] MSP_UNMAPPED_DATA = 8'h00;
   localparam logic [23:0] MSP_DELAY_RESET = 24'h000000;
   localparam logic [23:0] MSP_CNT_ONE = 24'h000001;
   localparam logic [23:0] MSP_CNT_ZERO = 24'h000000;

   // Mission sequencer states, one-hot
   typedef enum logic [3:0] {
      MSP_ST_IDLE = 4'h1,
      MSP_ST_DELAY = 4'h2,
      MSP_ST_ALARM_WAIT = 4'h4,
      MSP_ST_LOGGING = 4'h8
   } msp_state_e;

endpackage : msp_pkg

/* verification/msp_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// Host side of the byte register port
// ---------------------------------------------
module msp_host_model (
   input wire logic i_core_clk,
   output logic [15:0] o_reg_addr,
   output logic o_reg_rd,
   output logic o_reg_wr,
   output logic [7:0] o_reg_wdata,
   output logic o_read_lock
);
   // Idle bus at time zero
   initial
   begin
      o_reg_addr = '0;
      o_reg_rd = 1'b0;
      o_reg_wr = 1'b0;
      o_reg_wdata = '0;
      o_read_lock = 1'b0;
   end
   // One byte read
   task rd_byte(input logic [15:0] a);
      @(posedge i_core_clk);
      #1;
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(posedge i_core_clk);
      #1;
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
   endtask : rd_byte
   // One byte write
   task wr_byte(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      #1;
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(posedge i_core_clk);
      #1;
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
   endtask : wr_byte
   // Read lock
   task set_lock(input logic v);
      @(posedge i_core_clk);
      #1;
      o_read_lock = v;
   endtask : set_lock
endmodule : msp_host_model
`default_nettype wire

/* verification/msp_mission_regs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// Port checker for the mission registers
// ---------------------------------------------
module msp_props (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [15:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic i_reg_wr,
   input wire logic i_clear_memory_cmd,
   input wire logic i_start_mission_cmd,
   input wire logic i_stop_mission_cmd,
   input wire logic i_alarm_triggered_start,
   input wire logic i_temp_alarm,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_write_refused,
   input wire logic o_mission_active_flag,
   input wire logic o_memory_cleared_flag,
   input wire logic o_awaiting_alarm_flag,
   input wire logic o_clear_alarm_flags,
   input wire logic o_start_refused
);
   import msp_pkg::*;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // Start to be taken
   wire logic start_ok = i_start_mission_cmd && o_memory_cleared_flag && !o_mission_active_flag;
   // Any of the three delay bytes
   wire logic dly_addr = i_reg_addr >= MSP_ADDR_DELAY_LOW && i_reg_addr <= MSP_ADDR_DELAY_HIGH;
   a_status_fixed_bits: assert property (i_reg_rd && i_reg_addr == MSP_ADDR_STATUS |=>
      o_reg_rdata[7:6] == 2'h3 && !o_reg_rdata[5] && !o_reg_rdata[2] && !o_reg_rdata[0])
      else $error("fixed bits");
   a_status_read_only: assert property (i_reg_wr && i_reg_addr == MSP_ADDR_STATUS |=> o_write_refused)
      else $error("status write taken");
   a_start_sets_active: assert property (start_ok |=> o_mission_active_flag && !o_memory_cleared_flag)
      else $error("start not taken");
   a_stop_ends_mission: assert property (i_stop_mission_cmd && o_mission_active_flag |=> !o_mission_active_flag)
      else $error("stop ignored");
   a_clear_sets_flag: assert property (i_clear_memory_cmd && !o_mission_active_flag && !i_start_mission_cmd
      |=> o_memory_cleared_flag && o_clear_alarm_flags) else $error("clear incomplete");
   a_uncleared_start: assert property (i_start_mission_cmd && !o_memory_cleared_flag
      |=> o_start_refused && !$rose(o_mission_active_flag)) else $error("uncleared start");
   a_await_set: assert property (start_ok && i_alarm_triggered_start |=> o_awaiting_alarm_flag)
      else $error("await not set");
   a_await_holds: assert property (o_awaiting_alarm_flag && !i_temp_alarm |=> o_awaiting_alarm_flag)
      else $error("await lost");
   a_await_clears: assert property (i_temp_alarm && !i_start_mission_cmd |=> !o_awaiting_alarm_flag)
      else $error("await kept");
   a_delay_locked: assert property (i_reg_wr && dly_addr && o_mission_active_flag |=> o_write_refused)
      else $error("delay written");
endmodule : msp_props
bind msp_mission_regs msp_props u_props (.*);
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// Self-checking bench
// ---------------------------------------------
module tb;
   import msp_pkg::*;
   localparam logic [6:0] C_CLR = 7'h01;
   localparam logic [6:0] C_START = 7'h02;
   localparam logic [6:0] C_STOP = 7'h04;
   localparam logic [6:0] C_FORCE = 7'h08;
   localparam logic [6:0] C_MIN = 7'h10;
   localparam logic [6:0] C_SMP = 7'h20;
   localparam logic [6:0] C_TEMP = 7'h40;
   logic clk;
   logic rst_n;
   logic [6:0] ev; // Command and event pulses
   logic ats;
   logic [47:0] rtc;
   wire logic [15:0] addr;
   wire logic rd;
   wire logic wr;
   wire logic [7:0] wdata;
   wire logic lock;
   wire logic [7:0] rdata;
   wire logic rvalid;
   wire logic act;
   wire logic memory_cleared_flag;
   wire logic take;
   wire logic atest;
   wire logic clr_al;
   wire logic st_ref;
   logic [7:0] exp_q[$]; // Expected read bytes, oldest first
   string name_q[$];
   int error_cnt = 0;
   int comparisons = 0;
   int take_cnt = 0;
   int test_cnt = 0;
   int n;
   logic [23:0] dev_exp = 24'h0;
   logic [23:0] dly;
   msp_host_model host (.i_core_clk(clk), .o_reg_addr(addr), .o_reg_rd(rd), .o_reg_wr(wr),
      .o_reg_wdata(wdata), .o_read_lock(lock));
   msp_mission_regs dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr),
      .i_reg_wdata(wdata), .i_read_lock(lock), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_write_refused(),
      .i_clear_memory_cmd(ev[0]), .i_start_mission_cmd(ev[1]), .i_stop_mission_cmd(ev[2]),
      .i_forced_conv_cmd(ev[3]), .i_alarm_triggered_start(ats), .i_minute_tick(ev[4]), .i_sample_tick(ev[5]),
      .i_temp_alarm(ev[6]), .i_rtc_time(rtc), .o_mission_active_flag(act), .o_memory_cleared_flag(memory_cleared_flag),
      .o_awaiting_alarm_flag(), .o_take_sample(take), .o_alarm_test(atest), .o_clear_alarm_flags(clr_al),
      .o_start_refused(st_ref));
   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task end_of_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   // Note expectation, then read
   task rdb(input logic [15:0] a, input logic [7:0] e, input string nm);
      exp_q.push_back(e);
      name_q.push_back(nm);
      host.rd_byte(a);
   endtask : rdb
   // Coherent group read, low byte first under lock
   task rd24(input logic [15:0] a, input logic [23:0] e, input string nm);
      host.set_lock(1'b1);
      rdb(a, e[7:0], nm);
      rdb(a + 16'h1, e[15:8], nm);
      rdb(a + 16'h2, e[23:16], nm);
      host.set_lock(1'b0);
   endtask : rd24
   task wr24(input logic [23:0] d);
      host.wr_byte(MSP_ADDR_DELAY_LOW, d[7:0]);
      host.wr_byte(MSP_ADDR_DELAY_MID, d[15:8]);
      host.wr_byte(MSP_ADDR_DELAY_HIGH, d[23:16]);
   endtask : wr24
   task pulse(input logic [6:0] m);
      @(posedge clk);
      #1;
      ev = m;
      @(posedge clk);
      #1;
      ev = '0;
   endtask : pulse
   // Wake pulse counters
   always @(posedge clk)
   begin
      if (take === 1'b1) take_cnt++;
      if (atest === 1'b1) test_cnt++;
   end
   // Oldest note against each answer
   always @(posedge clk)
   begin
      if (rvalid === 1'b1)
      begin
         if (exp_q.size() == 0) check("unexpected read", 24'h1, 24'h0);
         else check(name_q.pop_front(), {16'h0, rdata}, {16'h0, exp_q.pop_front()});
      end
   end
   // Watchdog
   initial
   begin
      #40000;
      error_cnt++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(32'hf52a));
      ev = '0;
      ats = 1'b0;
      rtc = {16'($urandom), 32'($urandom)};
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      rdb(MSP_ADDR_STATUS, 8'hc0, "status");
      host.wr_byte(MSP_ADDR_STATUS, 8'hff);
      rdb(MSP_ADDR_STATUS, 8'hc0, "status");
      rdb(16'h021f, 8'h00, "unmapped");
      pulse(C_START);
      check("start_refused", st_ref, 24'h1);
      dly = 24'($urandom);
      wr24(dly);
      rd24(MSP_ADDR_DELAY_LOW, dly, "delay");
      wr24(24'h2);
      pulse(C_CLR);
      check("clear_alarms", clr_al, 24'h1);
      rdb(MSP_ADDR_STATUS, 8'hc8, "status");
      rd24(MSP_ADDR_MSAMP_LOW, 24'h0, "mission count");
      rd24(MSP_ADDR_STAMP_SEC, 24'h0, "stamp");
      pulse(C_START);
      check("active", act, 24'h1);
      rdb(MSP_ADDR_STATUS, 8'hc2, "status");
      host.wr_byte(MSP_ADDR_DELAY_LOW, 8'h55);
      rd24(MSP_ADDR_DELAY_LOW, 24'h2, "delay");
      pulse(C_MIN);
      repeat (2) @(posedge clk);
      check("early sample", take_cnt, 24'h0);
      pulse(C_MIN);
      repeat (2) @(posedge clk);
      check("first sample", take_cnt, 24'h1);
      n = 2 + $urandom % 4;
      repeat (n) pulse(C_SMP);
      dev_exp = dev_exp + 24'(n + 1);
      rd24(MSP_ADDR_STAMP_SEC, rtc[23:0], "stamp low");
      rd24(MSP_ADDR_STAMP_DATE, rtc[47:24], "stamp high");
      rd24(MSP_ADDR_MSAMP_LOW, 24'(n + 1), "mission count");
      rd24(MSP_ADDR_DSAMP_LOW, dev_exp, "device count");
      pulse(C_STOP);
      rdb(MSP_ADDR_STATUS, 8'hc0, "status");
      repeat (2) pulse(C_FORCE);
      dev_exp = dev_exp + 24'h2;
      rd24(MSP_ADDR_DSAMP_LOW, dev_exp, "device count");
      wr24(24'h0);
      ats = 1'b1;
      pulse(C_CLR);
      pulse(C_START);
      rdb(MSP_ADDR_STATUS, 8'hd2, "status");
      pulse(C_SMP);
      repeat (2) @(posedge clk);
      check("alarm test", test_cnt, 24'h1);
      dev_exp = dev_exp + 24'h1;
      pulse(C_STOP);
      rdb(MSP_ADDR_STATUS, 8'hd0, "status");
      pulse(C_CLR);
      rdb(MSP_ADDR_STATUS, 8'hd8, "status");
      pulse(C_TEMP);
      rdb(MSP_ADDR_STATUS, 8'hc8, "status");
      rd24(MSP_ADDR_DSAMP_LOW, dev_exp, "device count");
      repeat (3) @(posedge clk);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
